// file: logic/msc_defines.vh
// Constants for the module stop and sleep control block
// Operation
// - Both module-stop registers are 8-bit read/write and reset to zero.
// - Bits 7 to 5 and 3 of module-stop registers read zero, ignore writes.
// - First register bit 4 set stops compare-match timer clock.
// - First register bit 2 set stops serial channel 2 clock.
// - First register bit 1 set stops serial channel 1 clock.
// - First register bit 0 set stops serial channel 0 clock.
// - Second register bit 4 set stops host interface clock.
// - Second register bit 2 set stops FIFO serial I/O clock.
// - Second register bit 1 set stops PHY interface clock.
// - Second register bit 0 stops Ethernet MAC and its DMA together.
// - Sleep instruction with standby select clear enters sleep mode.
// - CPU halts right after sleep instruction, its registers kept unchanged.
// - In sleep, peripherals run and clock output pin stays driven.
// - Accepted interrupt of any source ends sleep, then exception runs.
// - IRQ or peripheral interrupt not above mask level is not accepted.
// - Power-on reset or debug-interface reset ends sleep mode.
// - Standby select is bit 7 of main standby control, resets zero.
// - Clearing a stop bit or power-on reset restores the peripheral clock.
`ifndef MSC_DEFINES_VH
`define MSC_DEFINES_VH

// Register bus
`define MSC_ADDR_W 8
`define MSC_DATA_W 8
`define MSC_OFS_TIMER_SERIAL 8'h00
`define MSC_OFS_HOST_NET 8'h04
`define MSC_OFS_MAIN_STANDBY 8'h08
`define MSC_OFS_SLEEP_STATUS 8'h0c
`define MSC_OFS_WAKE_CAUSE 8'h10
`define MSC_OFS_CLK_STATUS 8'h14

// Reset values and writable masks
`define MSC_RST_STOP 8'h00
`define MSC_RST_MAIN 8'h00
`define MSC_STOP_WMASK 8'h17
`define MSC_MAIN_WMASK 8'h80

// Field positions in the module-stop and main standby control registers
`define MSC_BIT_TIMER 4
`define MSC_BIT_SER2 2
`define MSC_BIT_SER1 1
`define MSC_BIT_SER0 0
`define MSC_BIT_HOST 4
`define MSC_BIT_FSIO 2
`define MSC_BIT_PHY 1
`define MSC_BIT_MAC 0
`define MSC_BIT_STANDBY_SEL 7

// Wake cause bits
`define MSC_WC_NMI 0
`define MSC_WC_DBG 1
`define MSC_WC_IRQ 2
`define MSC_WC_PERIPH 3
`define MSC_WC_DBG_RST 4
`define MSC_WC_W 5

// Sleep state codes
`define MSC_ST_RUN 1'b0
`define MSC_ST_SLEEP 1'b1

// Gated peripheral clocks
`define MSC_NUM_GATES 8
`define MSC_PRIO_W 4

`endif

// file: logic/msc_clk_gate.v
// Glitch-free clock gate for one peripheral clock
`timescale 1ns/100ps
module msc_clk_gate (
  // Clock and reset
  input wire i_core_clk,
  input wire i_nrst,
  // Control
  input wire i_run,
  // Gated clock
  output wire o_gclk,
  output wire o_en
);

  reg en_reg;

  // Enable changes only while the clock is low, so no pulse is cut short
  always @(negedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      en_reg <= 1'b1;
    end else begin
      en_reg <= i_run;
    end
  end

  assign o_gclk = i_core_clk & en_reg;
  assign o_en = en_reg;

endmodule

// file: logic/msc_sleep_ctl.v
// Sleep entry and wake state machine
`timescale 1ns/100ps
`include "msc_defines.vh"
module msc_sleep_ctl #(
  parameter PRIO_W = `MSC_PRIO_W
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_nrst,
  // Sleep request
  input wire i_sleep_exec,
  input wire i_standby_sel,
  // Wake sources
  input wire i_nmi_req,
  input wire i_dbg_int_req,
  input wire i_irq_req,
  input wire [PRIO_W-1:0] i_irq_level,
  input wire i_periph_req,
  input wire [PRIO_W-1:0] i_periph_level,
  input wire [PRIO_W-1:0] i_cpu_mask,
  input wire i_dbg_reset,
  // Status
  output reg o_sleeping,
  output reg o_wake,
  output reg o_standby_req,
  output reg [`MSC_WC_W-1:0] o_cause
);

  localparam ST_RUN = `MSC_ST_RUN;
  localparam ST_SLEEP = `MSC_ST_SLEEP;

  reg state_reg;
  reg state_next;
  wire irq_ok;
  wire per_ok;
  wire accept;

  // Masked sources stay pending and do not wake
  assign irq_ok = i_irq_req & (i_irq_level > i_cpu_mask);
  assign per_ok = i_periph_req & (i_periph_level > i_cpu_mask);
  assign accept = i_nmi_req | i_dbg_int_req | irq_ok | per_ok;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (i_sleep_exec && !i_standby_sel) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (i_dbg_reset || accept) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= ST_RUN;
      o_sleeping <= 1'b0;
      o_wake <= 1'b0;
      o_standby_req <= 1'b0;
      o_cause <= {`MSC_WC_W{1'b0}};
    end else begin
      state_reg <= state_next;
      o_sleeping <= (state_next == ST_SLEEP);
      o_wake <= (state_reg == ST_SLEEP) && !i_dbg_reset && accept;
      o_standby_req <= (state_reg == ST_RUN) && i_sleep_exec &&
                       i_standby_sel;
      if (state_reg == ST_SLEEP && (i_dbg_reset || accept)) begin
        o_cause <= {i_dbg_reset, per_ok, irq_ok, i_dbg_int_req, i_nmi_req};
      end
    end
  end

endmodule

// file: logic/msc_top.v
// Module stop and sleep control: registers, clock gates and sleep control
`timescale 1ns/100ps
`include "msc_defines.vh"
module msc_top #(
  parameter ADDR_W = `MSC_ADDR_W,
  parameter PRIO_W = `MSC_PRIO_W
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_nrst,
  // Register port
  input wire [ADDR_W-1:0] i_addr,
  input wire [`MSC_DATA_W-1:0] i_wr_data,
  input wire i_wr,
  input wire i_rd,
  output reg [`MSC_DATA_W-1:0] o_rd_data,
  // CPU sleep interface
  input wire i_sleep_exec,
  output reg o_cpu_halt,
  output reg o_standby_req,
  output reg o_wake_exception,
  // Wake sources
  input wire i_nmi_req,
  input wire i_dbg_int_req,
  input wire i_irq_req,
  input wire [PRIO_W-1:0] i_irq_level,
  input wire i_periph_req,
  input wire [PRIO_W-1:0] i_periph_level,
  input wire [PRIO_W-1:0] i_cpu_mask,
  input wire i_dbg_reset,
  // External clock output
  output reg o_clock_output_pin_en,
  // Peripheral clocks
  output wire o_compare_match_timer_clk,
  output wire o_serial_channel_2_clk,
  output wire o_serial_channel_1_clk,
  output wire o_serial_channel_0_clk,
  output wire o_host_interface_clk,
  output wire o_fifo_serial_io_clk,
  output wire o_phy_port_clk,
  output wire o_ethernet_mac_clk,
  output wire o_ethernet_dma_clk
);

  // Software registers
  reg [`MSC_DATA_W-1:0] timer_serial_clock_stop_reg;
  reg [`MSC_DATA_W-1:0] host_net_clock_stop_reg;
  reg [`MSC_DATA_W-1:0] main_standby_control_reg;
  reg [`MSC_WC_W-1:0] wake_cause_reg;
  reg [`MSC_DATA_W-1:0] rd_data_next;

  // Decoded accesses
  wire sel_ts;
  wire sel_hn;
  wire sel_main;
  wire sel_slp;
  wire sel_wc;
  wire sel_clk;
  wire wr_ts;
  wire wr_hn;
  wire wr_main;
  wire wr_wc;

  // Stop bits in gate order
  wire [`MSC_NUM_GATES-1:0] stop_vec;
  wire [`MSC_NUM_GATES-1:0] gclk_vec;
  wire [`MSC_NUM_GATES-1:0] gen_vec;

  // Sleep controller outputs
  wire sleeping;
  wire wake;
  wire standby_req;
  wire [`MSC_WC_W-1:0] cause;
  wire standby_select;
  reg sleeping_d_reg;
  wire wake_cause_pulse;

  // Address decode
  assign sel_ts = (i_addr == `MSC_OFS_TIMER_SERIAL);
  assign sel_hn = (i_addr == `MSC_OFS_HOST_NET);
  assign sel_main = (i_addr == `MSC_OFS_MAIN_STANDBY);
  assign sel_slp = (i_addr == `MSC_OFS_SLEEP_STATUS);
  assign sel_wc = (i_addr == `MSC_OFS_WAKE_CAUSE);
  assign sel_clk = (i_addr == `MSC_OFS_CLK_STATUS);

  assign wr_ts = i_wr & sel_ts;
  assign wr_hn = i_wr & sel_hn;
  assign wr_main = i_wr & sel_main;
  assign wr_wc = i_wr & sel_wc;

  // First module-stop register
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      timer_serial_clock_stop_reg <= `MSC_RST_STOP;
    end else if (wr_ts) begin
      // Reserved bits never store
      timer_serial_clock_stop_reg <= i_wr_data & `MSC_STOP_WMASK;
    end
  end

  // Second module-stop register
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      host_net_clock_stop_reg <= `MSC_RST_STOP;
    end else if (wr_hn) begin
      host_net_clock_stop_reg <= i_wr_data & `MSC_STOP_WMASK;
    end
  end

  // Main standby control, only standby select is kept
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      main_standby_control_reg <= `MSC_RST_MAIN;
    end else if (wr_main) begin
      main_standby_control_reg <= i_wr_data & `MSC_MAIN_WMASK;
    end
  end

  assign standby_select = main_standby_control_reg[`MSC_BIT_STANDBY_SEL];

  // Wake cause: sticky, write one to clear, a new cause wins over the clear
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wake_cause_reg <= {`MSC_WC_W{1'b0}};
    end else begin
      wake_cause_reg <= (wake_cause_reg &
                         ~(wr_wc ? i_wr_data[`MSC_WC_W-1:0] :
                           {`MSC_WC_W{1'b0}})) |
                        (wake_cause_pulse ? cause : {`MSC_WC_W{1'b0}});
    end
  end

  // One-cycle marker that the sleep controller just left sleep

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sleeping_d_reg <= 1'b0;
    end else begin
      sleeping_d_reg <= sleeping;
    end
  end

  assign wake_cause_pulse = sleeping_d_reg & ~sleeping;

  // Read mux, data appears in the cycle after the strobe
  always @* begin
    rd_data_next = {`MSC_DATA_W{1'b0}};
    if (sel_ts) begin
      rd_data_next = timer_serial_clock_stop_reg & `MSC_STOP_WMASK;
    end else if (sel_hn) begin
      rd_data_next = host_net_clock_stop_reg & `MSC_STOP_WMASK;
    end else if (sel_main) begin
      rd_data_next = main_standby_control_reg;
    end else if (sel_slp) begin
      rd_data_next = {{(`MSC_DATA_W-2){1'b0}}, o_clock_output_pin_en,
                      sleeping};
    end else if (sel_wc) begin
      rd_data_next = {{(`MSC_DATA_W-`MSC_WC_W){1'b0}}, wake_cause_reg};
    end else if (sel_clk) begin
      rd_data_next = gen_vec;
    end
  end

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rd_data <= {`MSC_DATA_W{1'b0}};
    end else if (i_rd) begin
      o_rd_data <= rd_data_next;
    end else begin
      o_rd_data <= {`MSC_DATA_W{1'b0}};
    end
  end

  // Gate order: timer, ser2, ser1, ser0, host, fifo serial, phy, mac+dma
  assign stop_vec[7] = timer_serial_clock_stop_reg[`MSC_BIT_TIMER];
  assign stop_vec[6] = timer_serial_clock_stop_reg[`MSC_BIT_SER2];
  assign stop_vec[5] = timer_serial_clock_stop_reg[`MSC_BIT_SER1];
  assign stop_vec[4] = timer_serial_clock_stop_reg[`MSC_BIT_SER0];
  assign stop_vec[3] = host_net_clock_stop_reg[`MSC_BIT_HOST];
  assign stop_vec[2] = host_net_clock_stop_reg[`MSC_BIT_FSIO];
  assign stop_vec[1] = host_net_clock_stop_reg[`MSC_BIT_PHY];
  assign stop_vec[0] = host_net_clock_stop_reg[`MSC_BIT_MAC];

  // One gate per stop bit; the enable settles half a cycle after the write
  genvar g;
  generate
    for (g = 0; g < `MSC_NUM_GATES; g = g + 1) begin : gate
      msc_clk_gate u_gate (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_run(~stop_vec[g]),
        .o_gclk(gclk_vec[g]),
        .o_en(gen_vec[g])
      );
    end
  endgenerate

  assign o_compare_match_timer_clk = gclk_vec[7];
  assign o_serial_channel_2_clk = gclk_vec[6];
  assign o_serial_channel_1_clk = gclk_vec[5];
  assign o_serial_channel_0_clk = gclk_vec[4];
  assign o_host_interface_clk = gclk_vec[3];
  assign o_fifo_serial_io_clk = gclk_vec[2];
  assign o_phy_port_clk = gclk_vec[1];
  // MAC and its DMA share one gate so they always stop together
  assign o_ethernet_mac_clk = gclk_vec[0];
  assign o_ethernet_dma_clk = gclk_vec[0];

  // Sleep state machine
  msc_sleep_ctl #(
    .PRIO_W(PRIO_W)
  ) u_sleep (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_sleep_exec(i_sleep_exec),
    .i_standby_sel(standby_select),
    .i_nmi_req(i_nmi_req),
    .i_dbg_int_req(i_dbg_int_req),
    .i_irq_req(i_irq_req),
    .i_irq_level(i_irq_level),
    .i_periph_req(i_periph_req),
    .i_periph_level(i_periph_level),
    .i_cpu_mask(i_cpu_mask),
    .i_dbg_reset(i_dbg_reset),
    .o_sleeping(sleeping),
    .o_wake(wake),
    .o_standby_req(standby_req),
    .o_cause(cause)
  );

  // CPU-facing outputs
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cpu_halt <= 1'b0;
      o_wake_exception <= 1'b0;
      o_standby_req <= 1'b0;
      o_clock_output_pin_en <= 1'b1;
    end else begin
      // Halt holds the CPU frozen; its register file is not touched here
      o_cpu_halt <= sleeping;
      o_wake_exception <= wake;
      o_standby_req <= standby_req;
      // Sleep keeps the external clock running
      o_clock_output_pin_en <= 1'b1;
    end
  end

endmodule

// file: dv/msc_monitor.sv
// Port checks for the module stop and sleep control block
`timescale 1ns/100ps
module msc_monitor #(
  parameter ADDR_W = 8,
  parameter PRIO_W = 4
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_nrst,
  // Register port
  input wire [ADDR_W-1:0] i_addr,
  input wire [7:0] i_wr_data,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rd_data,
  // Sleep and wake
  input wire i_sleep_exec,
  input wire o_cpu_halt,
  input wire o_standby_req,
  input wire o_wake_exception,
  input wire i_nmi_req,
  input wire i_dbg_int_req,
  input wire i_irq_req,
  input wire [PRIO_W-1:0] i_irq_level,
  input wire i_periph_req,
  input wire [PRIO_W-1:0] i_periph_level,
  input wire [PRIO_W-1:0] i_cpu_mask,
  input wire i_dbg_reset,
  // Clocks out
  input wire o_clock_output_pin_en,
  input wire o_compare_match_timer_clk,
  input wire o_serial_channel_2_clk,
  input wire o_serial_channel_1_clk,
  input wire o_serial_channel_0_clk,
  input wire o_host_interface_clk,
  input wire o_fifo_serial_io_clk,
  input wire o_phy_port_clk,
  input wire o_ethernet_mac_clk,
  input wire o_ethernet_dma_clk
);
  reg [7:0] ts_reg;
  reg [7:0] hn_reg;
  reg standby_select_reg;
  wire [7:0] stop_rd = i_addr[2] ? hn_reg : ts_reg;
  wire [3:0] ts_run = ~{ts_reg[4], ts_reg[2:0]};
  wire [4:0] hn_run = ~{hn_reg[4], hn_reg[2:0], hn_reg[0]};
  wire acc = i_nmi_req | i_dbg_int_req |
    (i_irq_req && i_irq_level > i_cpu_mask) |
    (i_periph_req && i_periph_level > i_cpu_mask);
  wire quiet = !acc && !i_dbg_reset;

  // Shadow of what software has written
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ts_reg <= 8'h00;
      hn_reg <= 8'h00;
      standby_select_reg <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == 8'h00)
        ts_reg <= i_wr_data & 8'h17;
      if (i_addr == 8'h04)
        hn_reg <= i_wr_data & 8'h17;
      if (i_addr == 8'h08)
        standby_select_reg <= i_wr_data[7];
    end
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  a_stop_read: assert property (
    i_rd && (i_addr == 8'h00 || i_addr == 8'h04)
    |=> o_rd_data == $past(stop_rd)) else $error("stop register readback");
  a_read_idle: assert property (
    !i_rd || i_addr > 8'h14 |=> o_rd_data == 8'h00)
    else $error("read data not zero");
  a_gate_first: assert property (
    @(negedge i_core_clk) {o_compare_match_timer_clk, o_serial_channel_2_clk,
    o_serial_channel_1_clk, o_serial_channel_0_clk} == $past(ts_run))
    else $error("timer or serial clock gate wrong");
  a_gate_second: assert property (
    @(negedge i_core_clk) {o_host_interface_clk, o_fifo_serial_io_clk,
    o_phy_port_clk, o_ethernet_mac_clk, o_ethernet_dma_clk} == $past(hn_run))
    else $error("host or network clock gate wrong");
  a_sleep_entry: assert property (
    (i_sleep_exec && !o_cpu_halt && !standby_select_reg && quiet) ##1 quiet
    |=> o_cpu_halt) else $error("sleep not entered");
  a_standby_sel: assert property (
    i_sleep_exec && !o_cpu_halt && standby_select_reg
    |-> ##2 o_standby_req && !o_cpu_halt) else $error("standby not requested");
  a_wake_accept: assert property (
    o_cpu_halt && acc && !i_dbg_reset && !$past(acc) && !$past(i_dbg_reset)
    |-> ##2 o_wake_exception && !o_cpu_halt) else $error("wake not taken");
  a_irq_refused: assert property (
    o_cpu_halt && quiet && $past(quiet) |=> o_cpu_halt)
    else $error("sleep left without accepted source");
  a_dbg_reset_end: assert property (
    o_cpu_halt && i_dbg_reset && !acc && !$past(i_dbg_reset)
    |-> ##2 !o_cpu_halt && !o_wake_exception) else $error("debug reset wake");
  a_clkout_on: assert property (
    o_clock_output_pin_en) else $error("clock output disabled");
  a_wake_single: assert property (
    o_wake_exception |=> !o_wake_exception) else $error("wake pulse too long");

  c_sleep: cover property ($rose(o_cpu_halt));
  c_wake: cover property (o_wake_exception);
  c_standby: cover property (o_standby_req);
endmodule

bind msc_top msc_monitor #(.ADDR_W(ADDR_W), .PRIO_W(PRIO_W)) u_mon (.*);

// file: dv/tb_top.sv
// Self-checking testbench for module stop and sleep control
`timescale 1ns/100ps
module tb_top;
  logic i_core_clk = 0;
  logic i_nrst = 0;
  logic [7:0] i_addr = 0;
  logic [7:0] i_wr_data = 0;
  logic i_wr = 0;
  logic i_rd = 0;
  logic i_sleep_exec = 0;
  logic [4:0] src = 0;
  logic [3:0] i_irq_level = 0;
  logic [3:0] i_periph_level = 0;
  logic [3:0] i_cpu_mask = 0;
  logic [7:0] o_rd_data;
  logic o_cpu_halt, o_standby_req, o_wake_exception, o_clock_output_pin_en;
  wire [8:0] gclk;
  logic [7:0] ts, hn, d;
  int failures = 0, n_compared = 0, seed = 82387, i, k;

  always #2.5 i_core_clk = ~i_core_clk;

  msc_top u_dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
    .i_sleep_exec(i_sleep_exec), .o_cpu_halt(o_cpu_halt),
    .o_standby_req(o_standby_req), .o_wake_exception(o_wake_exception),
    .i_nmi_req(src[0]), .i_dbg_int_req(src[1]), .i_irq_req(src[2]),
    .i_irq_level(i_irq_level), .i_periph_req(src[3]),
    .i_periph_level(i_periph_level), .i_cpu_mask(i_cpu_mask),
    .i_dbg_reset(src[4]), .o_clock_output_pin_en(o_clock_output_pin_en),
    .o_compare_match_timer_clk(gclk[8]), .o_serial_channel_2_clk(gclk[7]),
    .o_serial_channel_1_clk(gclk[6]), .o_serial_channel_0_clk(gclk[5]),
    .o_host_interface_clk(gclk[4]), .o_fifo_serial_io_clk(gclk[3]),
    .o_phy_port_clk(gclk[2]), .o_ethernet_mac_clk(gclk[1]),
    .o_ethernet_dma_clk(gclk[0]));

  task automatic stop_test;
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  function automatic logic [8:0] exp_g(input logic [7:0] a,
                                       input logic [7:0] b);
    exp_g = ~{a[4], a[2:0], b[4], b[2:0], b[0]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wr_data <= v;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 chk(o_rd_data, e);
  endtask

  // Gated clocks sampled in the high phase show their enables
  task automatic gchk;
    @(posedge i_core_clk);
    #1 chk(gclk, exp_g(ts, hn));
  endtask

  task automatic slp;
    @(posedge i_core_clk);
    i_sleep_exec <= 1'b1;
    @(posedge i_core_clk);
    i_sleep_exec <= 1'b0;
    @(posedge i_core_clk);
  endtask

  initial begin
    #100000;
    failures++;
    stop_test;
  end

  initial begin
    repeat (20) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    ts = 8'h00;
    hn = 8'h00;
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h00);
    chk(o_clock_output_pin_en, 1'b1);
    // Random stop patterns, reserved bits set too
    for (i = 0; i < 24; i++) begin
      d = 8'($random(seed));
      if (i < 2)
        d = 8'hff;
      if (i[0]) begin
        wr(8'h04, d);
        hn = d & 8'h17;
      end else begin
        wr(8'h00, d);
        ts = d & 8'h17;
      end
      gchk;
      rd(8'h00, ts);
      rd(8'h04, hn);
      rd(8'h14, 8'(exp_g(ts, hn) >> 1));
    end
    rd(8'hfc, 8'h00);
    wr(8'h08, 8'h00);
    i_cpu_mask <= 4'h5;
    for (k = 0; k < 5; k++) begin
      slp;
      i_irq_level <= 4'h5;
      i_periph_level <= 4'($random(seed)) % 4'h6;
      src <= 5'b01100;
      #1 chk(o_cpu_halt, 1'b1);
      repeat (4) @(posedge i_core_clk);
      #1 chk(o_cpu_halt, 1'b1);
      gchk;
      rd(8'h0c, 8'h03);
      @(posedge i_core_clk);
      i_irq_level <= 4'h6;
      i_periph_level <= 4'h6 + 4'($random(seed)) % 4'ha;
      src <= 5'(1 << k);
      repeat (2) @(posedge i_core_clk);
      #1 chk({o_cpu_halt, o_wake_exception}, {1'b0, k < 4});
      @(posedge i_core_clk);
      src <= 5'b00000;
      rd(8'h10, 8'(1 << k));
      wr(8'h10, 8'h1f);
    end
    wr(8'h08, 8'hff);
    rd(8'h08, 8'h80);
    slp;
    #1 chk({o_cpu_halt, o_standby_req}, 2'b01);
    wr(8'h08, 8'h00);
    wr(8'h00, 8'hff);
    wr(8'h04, 8'hff);
    slp;
    i_nrst <= 1'b0;
    ts = 8'h00;
    hn = 8'h00;
    repeat (2) @(posedge i_core_clk);
    #1 chk({o_cpu_halt, gclk}, {1'b0, 9'h1ff});
    @(posedge i_core_clk);
    i_nrst <= 1'b1;
    rd(8'h00, 8'h00);
    gchk;
    stop_test;
  end
endmodule
